//--- core/ser_defs.svh
/*
 Offsets, field positions, reset values and the used-condition mask for the status event reporting block.
 Assumes inclusion by bare name from core/ files.
*/
`ifndef SER_DEFS_SVH
`define SER_DEFS_SVH

// Register selects on the command port
`define SER_REG_STB 4'h0
`define SER_REG_SRE 4'h1
`define SER_REG_ESR 4'h2
`define SER_REG_ESE 4'h3
`define SER_REG_OCOND 4'h4
`define SER_REG_OEVT 4'h5
`define SER_REG_OENA 4'h6
`define SER_REG_ONTR 4'h7
`define SER_REG_OPTR 4'h8

// Status byte fields
`define SER_STB_ESB 5
`define SER_STB_MSS 6
`define SER_STB_OPER 7

// Standard event fields
`define SER_ESR_OPC 0
`define SER_ESR_RQC 1
`define SER_ESR_QYE 2
`define SER_ESR_DDE 3
`define SER_ESR_EXE 4
`define SER_ESR_CME 5
`define SER_ESR_URQ 6
`define SER_ESR_PON 7

// Operation condition fields in use
`define SER_OCOND_USED 16'h1E3B

// Reset and preset values
`define SER_ESE_RESET 8'h00
`define SER_SRE_RESET 8'h00
`define SER_OENA_RESET 16'h0000
`define SER_ONTR_RESET 16'h0000
`define SER_OPTR_RESET 16'h7FFF
`define SER_ESR_RESET 8'h80

`endif

//--- core/ser_pkg.sv
/*
 Types for the status event reporting block.
 Assumes ser_defs.svh supplies the numeric constants.
*/
package ser_pkg;
	typedef logic [7:0] ser_byte_t;
	typedef logic [15:0] ser_word_t;
endpackage

//--- core/ser_status.sv
/*
 Status event reporting: standard event group, operation group and status byte.
 Assumes a controller parser that issues one-cycle write/read strobes with a register select,
 and condition sources synchronous to ref_clk.
*/
`include "ser_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ser_status
	import ser_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [3:0] cmd_sel,
	input wire logic [15:0] cmd_wdata,
	input wire logic clear_status,
	input wire logic preset_status,
	input wire logic opc_armed_done,
	input wire logic err_query,
	input wire logic err_device,
	input wire logic err_execution,
	input wire logic err_command,
	input wire logic local_key,
	input wire logic iq_cal_busy,
	input wire logic settling,
	input wire logic sweeping,
	input wire logic bert_measuring,
	input wire logic wait_trigger,
	input wire logic dc_modulation_null,
	input wire logic baseband_summary,
	input wire logic sweep_calculating,
	input wire logic bert_syncing,
	input wire logic error_queue_nonempty,
	input wire logic questionable_summary,
	input wire logic message_available,
	output logic [15:0] cmd_rdata,
	output logic cmd_rvalid,
	output logic [7:0] status_byte,
	output logic master_summary_bit
);

	ser_byte_t standard_event_latch;
	ser_byte_t std_event_enable;
	ser_byte_t service_enable;
	ser_word_t operation_condition_live;
	ser_word_t prev_condition;
	ser_word_t operation_event;
	ser_word_t operation_enable;
	ser_word_t operation_ntr;
	ser_word_t operation_ptr;
	ser_byte_t next_status_byte;
	ser_byte_t std_new;
	ser_word_t oper_new;
	logic std_summary;
	logic oper_summary;
	logic next_mss;
	logic rd_esr;
	logic rd_oevt;

	function automatic logic sel_hit(input logic strobe, input logic [3:0] sel, input logic [3:0] want);
		sel_hit = strobe && (sel == want);
	endfunction

	assign rd_esr = sel_hit(cmd_rd, cmd_sel, `SER_REG_ESR);
	assign rd_oevt = sel_hit(cmd_rd, cmd_sel, `SER_REG_OEVT);

	always_comb
	begin
		operation_condition_live = '0;
		operation_condition_live[0] = iq_cal_busy;
		operation_condition_live[1] = settling;
		operation_condition_live[3] = sweeping;
		operation_condition_live[4] = bert_measuring;
		operation_condition_live[5] = wait_trigger;
		operation_condition_live[9] = dc_modulation_null;
		operation_condition_live[10] = baseband_summary;
		operation_condition_live[11] = sweep_calculating;
		operation_condition_live[12] = bert_syncing;
		operation_condition_live = operation_condition_live & `SER_OCOND_USED;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			prev_condition <= '0;
		else
			prev_condition <= operation_condition_live;
	end

	// Per-bit edge filters
	// Each condition bit gets its own filter pair
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_edge
			assign oper_new[gi] = (prev_condition[gi] && !operation_condition_live[gi] && operation_ntr[gi])
				|| (!prev_condition[gi] && operation_condition_live[gi] && operation_ptr[gi]);
		end
	endgenerate

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			operation_event <= '0;
		else if (rd_oevt || clear_status)
			operation_event <= oper_new;
		else
			operation_event <= operation_event | oper_new;
	end

	always_comb
	begin
		std_new = '0;
		std_new[`SER_ESR_OPC] = opc_armed_done;
		std_new[`SER_ESR_QYE] = err_query;
		std_new[`SER_ESR_DDE] = err_device;
		std_new[`SER_ESR_EXE] = err_execution;
		std_new[`SER_ESR_CME] = err_command;
		std_new[`SER_ESR_URQ] = local_key;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			standard_event_latch <= `SER_ESR_RESET;
		else if (rd_esr || clear_status)
			standard_event_latch <= std_new;
		else
			standard_event_latch <= standard_event_latch | std_new;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			std_event_enable <= `SER_ESE_RESET;
			service_enable <= `SER_SRE_RESET;
			operation_enable <= `SER_OENA_RESET;
			operation_ntr <= `SER_ONTR_RESET;
			operation_ptr <= `SER_OPTR_RESET;
		end
		else if (preset_status)
		begin
			operation_enable <= `SER_OENA_RESET;
			operation_ntr <= `SER_ONTR_RESET;
			operation_ptr <= `SER_OPTR_RESET;
		end
		else if (cmd_wr)
		begin
			case (cmd_sel)
				`SER_REG_ESE: std_event_enable <= cmd_wdata[7:0];
				`SER_REG_SRE: service_enable <= cmd_wdata[7:0] & 8'hBF;
				`SER_REG_OENA: operation_enable <= cmd_wdata;
				`SER_REG_ONTR: operation_ntr <= cmd_wdata;
				`SER_REG_OPTR: operation_ptr <= cmd_wdata;
				default: ;
			endcase
		end
	end

	assign std_summary = |(standard_event_latch & std_event_enable);
	assign oper_summary = |(operation_event & operation_enable);

	always_comb
	begin
		next_status_byte = '0;
		next_status_byte[2] = error_queue_nonempty;
		next_status_byte[3] = questionable_summary;
		next_status_byte[4] = message_available;
		next_status_byte[`SER_STB_ESB] = std_summary;
		next_status_byte[`SER_STB_OPER] = oper_summary;
		next_mss = |(next_status_byte & service_enable);
		next_status_byte[`SER_STB_MSS] = next_mss;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			status_byte <= '0;
			master_summary_bit <= 1'b0;
		end
		else
		begin
			status_byte <= next_status_byte;
			master_summary_bit <= next_mss;
		end
	end

	// Read data captured at the strobe, before the clear lands
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			cmd_rdata <= '0;
			cmd_rvalid <= 1'b0;
		end
		else
		begin
			cmd_rvalid <= cmd_rd;
			if (cmd_rd)
			begin
				case (cmd_sel)
					`SER_REG_STB: cmd_rdata <= {8'h00, next_status_byte};
					`SER_REG_SRE: cmd_rdata <= {8'h00, service_enable};
					`SER_REG_ESR: cmd_rdata <= {8'h00, standard_event_latch};
					`SER_REG_ESE: cmd_rdata <= {8'h00, std_event_enable};
					`SER_REG_OCOND: cmd_rdata <= operation_condition_live;
					`SER_REG_OEVT: cmd_rdata <= operation_event;
					`SER_REG_OENA: cmd_rdata <= operation_enable;
					`SER_REG_ONTR: cmd_rdata <= operation_ntr;
					`SER_REG_OPTR: cmd_rdata <= operation_ptr;
					default: cmd_rdata <= '0;
				endcase
			end
		end
	end

endmodule // ser_status

`default_nettype wire

//--- test/ser_status_sva.sv
/*
 Port checks for ser_status.
 Bound to ser_status from the bench top file.
*/
`include "ser_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ser_status_sva
	import ser_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [3:0] cmd_sel,
	input wire logic message_available,
	input wire logic [15:0] cmd_rdata,
	input wire logic cmd_rvalid,
	input wire logic [7:0] status_byte,
	input wire logic master_summary_bit
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_read_answer: assert property (cmd_rd |=> cmd_rvalid) else $error("read got no answer");
	a_answer_cause: assert property (cmd_rvalid |-> $past(cmd_rd)) else $error("answer without read");
	a_write_silent: assert property (cmd_wr && !cmd_rd |=> !cmd_rvalid) else $error("write answered");
	a_mss_copy: assert property (master_summary_bit == status_byte[6]) else $error("summary differs");
	a_stb_low_zero: assert property (status_byte[1:0] == 2'h0) else $error("status low bits set");
	a_msg_follow: assert property (status_byte[4] == $past(message_available)) else $error("message bit");
	a_esr_rqc_zero: assert property (cmd_rvalid && $past(cmd_sel) == `SER_REG_ESR |-> !cmd_rdata[1])
		else $error("request control set");
	a_ocond_unused: assert property (cmd_rvalid && $past(cmd_sel) == `SER_REG_OCOND
		|-> (cmd_rdata & ~(`SER_OCOND_USED)) == 16'h0000) else $error("unused condition bit");
	c_mss: cover property (master_summary_bit);
	c_oper: cover property (status_byte[7]);
	c_data: cover property (cmd_rvalid && cmd_rdata != 16'h0000);
endmodule // ser_status_sva
`default_nettype wire

//--- test/ser_ctrl_model.sv
/*
 Remote controller model issuing register commands and queries.
 Assumes ser_status strobe timing, driven on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_ctrl_model
	import ser_pkg::*;
(
	input wire logic ref_clk,
	input wire logic cmd_rvalid,
	input wire logic [15:0] cmd_rdata,
	output logic cmd_wr,
	output logic cmd_rd,
	output logic [3:0] cmd_sel,
	output logic [15:0] cmd_wdata
);
	initial
	begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_sel = 4'hF;
		cmd_wdata = 16'h5A5A;
	end
	// Released data inverted so stale values never match
	task automatic wr(input logic [3:0] s, input ser_word_t v);
		@(negedge ref_clk);
		cmd_sel = s;
		cmd_wdata = v;
		cmd_wr = 1'b1;
		@(negedge ref_clk);
		cmd_wr = 1'b0;
		cmd_wdata = ~v;
	endtask
	task automatic rd(input logic [3:0] s, output ser_word_t v);
		@(negedge ref_clk);
		cmd_sel = s;
		cmd_rd = 1'b1;
		@(negedge ref_clk);
		cmd_rd = 1'b0;
		v = (cmd_rvalid === 1'b1) ? cmd_rdata : 16'hXXXX;
	endtask
endmodule // ser_ctrl_model
`default_nettype wire

//--- test/ser_status_tb.sv
/*
 Self-checking bench for ser_status.
 Assumes the controller model and checker files compiled first.
*/
`include "ser_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ser_status_tb;
	import ser_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clear_status = 1'b0;
	logic preset_status = 1'b0;
	logic [5:0] ev = 6'h00;
	logic [8:0] cond = 9'h000;
	logic [2:0] lvl = 3'h0;
	logic cmd_wr, cmd_rd, cmd_rvalid, master_summary_bit;
	logic [3:0] cmd_sel;
	ser_word_t cmd_wdata, cmd_rdata, d;
	ser_byte_t status_byte;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [5:0] row_ev [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
	ser_byte_t row_esr [6] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
	ser_status i_ser_status (.opc_armed_done(ev[0]), .err_query(ev[1]), .err_device(ev[2]),
		.err_execution(ev[3]), .err_command(ev[4]), .local_key(ev[5]), .iq_cal_busy(cond[0]),
		.settling(cond[1]), .sweeping(cond[2]), .bert_measuring(cond[3]), .wait_trigger(cond[4]),
		.dc_modulation_null(cond[5]), .baseband_summary(cond[6]), .sweep_calculating(cond[7]),
		.bert_syncing(cond[8]), .error_queue_nonempty(lvl[0]), .questionable_summary(lvl[1]),
		.message_available(lvl[2]), .*);
	ser_ctrl_model i_ser_ctrl_model (.*);
	always #50 ref_clk = ~ref_clk;
	task automatic complete_run();
		$display("Comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			complete_run();
		end
	end
	task automatic chk(input ser_word_t seen, input ser_word_t exp, input string name);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Bit 6 of the argument is the clear-status pulse
	task automatic pulse(input logic [6:0] e, input int n);
		@(negedge ref_clk);
		ev = e[5:0];
		clear_status = e[6];
		@(negedge ref_clk);
		ev = 6'h00;
		clear_status = 1'b0;
		repeat (n) @(negedge ref_clk);
	endtask
	initial
	begin
		repeat (6) @(negedge ref_clk);
		sys_rst = 1'b0;
		i_ser_ctrl_model.rd(`SER_REG_ESR, d);
		chk(d, 16'h0080, "esr power on");
		i_ser_ctrl_model.rd(`SER_REG_ESR, d);
		chk(d, 16'h0000, "esr after read");
		for (int i = 0; i < 6; i++)
		begin
			pulse({1'b0, row_ev[i]}, 0);
			i_ser_ctrl_model.rd(`SER_REG_ESR, d);
			chk(d, {8'h00, row_esr[i]}, "esr row");
		end
		i_ser_ctrl_model.wr(`SER_REG_ESE, 16'h0020);
		i_ser_ctrl_model.wr(`SER_REG_SRE, 16'h0020);
		i_ser_ctrl_model.rd(`SER_REG_ESE, d);
		chk(d, 16'h0020, "ese readback");
		pulse(7'h10, 4);
		chk(status_byte, 16'h0060, "stb summary");
		chk({15'h0000, master_summary_bit}, 16'h0001, "mss");
		pulse(7'h50, 4);
		chk(status_byte, 16'h0060, "set beats clear");
		pulse(7'h40, 4);
		chk(status_byte, 16'h0000, "after clear");
		cond = 9'h1FF;
		i_ser_ctrl_model.wr(`SER_REG_OCOND, 16'h0000);
		i_ser_ctrl_model.rd(`SER_REG_OCOND, d);
		chk(d, 16'h1E3B, "ocond");
		i_ser_ctrl_model.wr(`SER_REG_OENA, 16'h0008);
		pulse(7'h00, 2);
		chk(status_byte, 16'h0080, "stb oper");
		i_ser_ctrl_model.rd(`SER_REG_OEVT, d);
		chk(d, 16'h1E3B, "oevt rise");
		i_ser_ctrl_model.rd(`SER_REG_OEVT, d);
		chk(d, 16'h0000, "oevt one set");
		i_ser_ctrl_model.wr(`SER_REG_ONTR, 16'h0008);
		cond = 9'h000;
		pulse(7'h00, 1);
		i_ser_ctrl_model.rd(`SER_REG_OEVT, d);
		chk(d, 16'h0008, "oevt fall");
		lvl = 3'h7;
		pulse(7'h00, 3);
		chk(status_byte, 16'h001C, "stb levels");
		@(negedge ref_clk);
		preset_status = 1'b1;
		@(negedge ref_clk);
		preset_status = 1'b0;
		i_ser_ctrl_model.rd(`SER_REG_ONTR, d);
		chk(d, 16'h0000, "ntr preset");
		i_ser_ctrl_model.rd(`SER_REG_OPTR, d);
		chk(d, 16'h7FFF, "ptr preset");
		i_ser_ctrl_model.rd(`SER_REG_OENA, d);
		chk(d, 16'h0000, "oena preset");
		i_ser_ctrl_model.wr(`SER_REG_SRE, 16'h00FF);
		i_ser_ctrl_model.rd(`SER_REG_SRE, d);
		chk(d, 16'h00BF, "sre bit 6 fixed");
		i_ser_ctrl_model.rd(4'hF, d);
		chk(d, 16'h0000, "unmapped read");
		complete_run();
	end
endmodule // ser_status_tb
bind ser_status ser_status_sva i_ser_status_sva (.*);
`default_nettype wire
